// *** hdl/acr_pkg.sv ***
package acr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ADC_CONTROL = 8'h01;
    localparam logic [7:0] ADDR_DAC_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_LEFT_VOLUME = 8'h03;
    localparam logic [7:0] ADDR_RIGHT_VOLUME = 8'h04;
    localparam logic [7:0] ADDR_SERIAL_PORT_FORMAT = 8'h05;
    localparam logic [7:0] ADDR_CONVERTER_STATUS = 8'h06;
    localparam logic [7:0] ADDR_CLOCK_RATIO = 8'h07;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field positions and writable masks
    // ------------------------------------------------------------
    localparam int ADC_SLEEP_BIT = 7;
    localparam int ADC_R_HPB_BIT = 6;
    localparam int ADC_L_HPB_BIT = 5;
    localparam int ADC_R_SIL_BIT = 4;
    localparam int ADC_L_SIL_BIT = 3;
    localparam int ADC_TRIM_RST_BIT = 2;
    localparam int ADC_TRIM_BUSY_BIT = 1;
    localparam int ADC_CLK_FAULT_BIT = 0;
    localparam logic [7:0] ADC_WMASK = 8'hFC;
    localparam int DAC_ZRUN_BIT = 6;
    localparam int DAC_R_SIL_BIT = 5;
    localparam int DAC_L_SIL_BIT = 4;
    localparam int DAC_STYLE_BIT = 3;
    localparam logic [7:0] DAC_WMASK = 8'h7B;
    localparam logic [7:0] SPF_WMASK = 8'h7F;
    localparam logic [7:0] MCR_WMASK = 8'h03;

    // ------------------------------------------------------------
    // Level and timing constants
    // ------------------------------------------------------------
    localparam logic [7:0] VOL_MAX_CODE = 8'hE3;
    localparam logic [7:0] VOL_MUTE_CODE = 8'hE4;
    localparam logic [9:0] ZERO_RUN_LEN = 10'h200;
    localparam logic [9:0] ZC_TIMEOUT = 10'h200;
    localparam logic [5:0] RAMP_DIV_8 = 6'h08;
    localparam logic [5:0] RAMP_DIV_4 = 6'h04;
    localparam logic [5:0] RAMP_DIV_16 = 6'h10;
    localparam logic [5:0] RAMP_DIV_32 = 6'h20;
    localparam int CLK_HZ = 20000000;
    localparam int TRIM_MS = 50;
    localparam int TRIM_CYCLES = CLK_HZ / 1000 * TRIM_MS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACR_RAMP_8 = 2'b00,
        ACR_RAMP_4 = 2'b01,
        ACR_RAMP_16 = 2'b10,
        ACR_RAMP_32 = 2'b11
    } acr_ramp_t;

    typedef enum logic [2:0] {
        ACR_TRIM_IDLE = 3'b001,
        ACR_TRIM_RUN = 3'b010,
        ACR_TRIM_DONE = 3'b100
    } acr_trim_state_t;

    typedef struct packed {
        logic adc_sleep;
        logic [1:0] highpass_bypass;
        logic [1:0] adc_silence;
        logic [1:0] tone_correction_select;
        logic bit_clock_edge_select;
        logic [1:0] output_word_format;
        logic [1:0] input_word_format;
        logic [1:0] master_clock_ratio;
    } acr_cfg_t;

endpackage

// *** hdl/acr_regs.sv ***
// Contract
// - I2C mode reads back; SPI mode write only
// - adc_sleep puts ADC in low power
// - Per-channel high-pass bypass bits 6 and 5
// - Per-channel ADC silence bits 4 and 3
// - 50 ms offset trim after reset release
// - offset_trim_busy high during trim
// - clock_fault_flag shows clocking error
// - 512 static samples mute channel independently
// - DAC silence bits mute via chosen style
// - Style 0 ramps in 0.5 dB steps
// - ramp_rate picks 8, 4, 16, 32 frames
// - Style 1 zero crossing, 512-sample timeout
// - Code 0.5 dB each; above 227 mutes
// - tone_correction_select picks de-emphasis filter
// - bit_clock_edge_select picks bit clock edge
// - output_word_format picks output framing
// - input_word_format uses same coding
// - Level pending high until level applied
// - Sticky peak meters cleared by status read
// - master_clock_ratio only matters in master mode
`timescale 1ns/1ps
`default_nettype none

module acr_regs #(
    parameter int TRIM_CYCLES = acr_pkg::TRIM_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_spi_mode,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire logic i_master_mode,
    input wire logic i_clock_error,
    input wire logic i_frame_tick,
    input wire logic [1:0] i_sample_valid,
    input wire logic [1:0] i_sample_static,
    input wire logic [1:0] i_zero_cross,
    input wire logic [5:0] i_peak_code,
    output acr_pkg::acr_cfg_t o_cfg,
    output logic [7:0] o_left_level,
    output logic [7:0] o_right_level,
    output logic [1:0] o_dac_mute,
    output logic o_trim_busy
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] meta;
    logic [2:0] sync;
    logic spi_mode;
    logic master_mode;
    logic clock_error;

    // Mode straps and clock fault come from outside this domain
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta <= 3'h0;
            sync <= 3'h0;
        end
        else
        begin
            meta <= {i_spi_mode, i_master_mode, i_clock_error};
            sync <= meta;
        end
    end
    assign spi_mode = sync[2];
    assign master_mode = sync[1];
    assign clock_error = sync[0];

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] adc_control;
    logic [7:0] dac_control;
    logic [7:0] left_output_volume;
    logic [7:0] right_output_volume;
    logic [7:0] serial_port_format;
    logic [7:0] clock_ratio_control;
    logic [1:0] level_pending;
    logic [2:0] left_peak_meter;
    logic [2:0] right_peak_meter;
    logic trim_busy;
    logic status_read;

    // Host writes; reserved and read-only bits are masked off
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            adc_control <= acr_pkg::REG_RESET;
            dac_control <= acr_pkg::REG_RESET;
            left_output_volume <= acr_pkg::REG_RESET;
            right_output_volume <= acr_pkg::REG_RESET;
            serial_port_format <= acr_pkg::REG_RESET;
            clock_ratio_control <= acr_pkg::REG_RESET;
        end
        else if (i_wr)
        begin
            case (i_addr)
                acr_pkg::ADDR_ADC_CONTROL: adc_control <= i_wdata & acr_pkg::ADC_WMASK;
                acr_pkg::ADDR_DAC_CONTROL: dac_control <= i_wdata & acr_pkg::DAC_WMASK;
                acr_pkg::ADDR_LEFT_VOLUME: left_output_volume <= i_wdata;
                acr_pkg::ADDR_RIGHT_VOLUME: right_output_volume <= i_wdata;
                acr_pkg::ADDR_SERIAL_PORT_FORMAT: serial_port_format <= i_wdata & acr_pkg::SPF_WMASK;
                acr_pkg::ADDR_CLOCK_RATIO: clock_ratio_control <= i_wdata & acr_pkg::MCR_WMASK;
                default: ;
            endcase
        end
    end

    // Configuration outputs for the converter and serial port logic
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_cfg <= '0;
        end
        else
        begin
            o_cfg.adc_sleep <= adc_control[acr_pkg::ADC_SLEEP_BIT];
            o_cfg.highpass_bypass <= {adc_control[acr_pkg::ADC_R_HPB_BIT],
                adc_control[acr_pkg::ADC_L_HPB_BIT]};
            o_cfg.adc_silence <= {adc_control[acr_pkg::ADC_R_SIL_BIT],
                adc_control[acr_pkg::ADC_L_SIL_BIT]};
            o_cfg.tone_correction_select <= serial_port_format[6:5];
            o_cfg.bit_clock_edge_select <= serial_port_format[4];
            o_cfg.output_word_format <= serial_port_format[3:2];
            o_cfg.input_word_format <= serial_port_format[1:0];
            // Ratio forced to 256 Fs outside master mode; code 11 behaves as 00
            if (!master_mode || clock_ratio_control[1:0] == 2'b11)
                o_cfg.master_clock_ratio <= 2'b00;
            else
                o_cfg.master_clock_ratio <= clock_ratio_control[1:0];
        end
    end

    // ------------------------------------------------------------
    // Offset trim sequencer
    // ------------------------------------------------------------
    acr_pkg::acr_trim_state_t trim_state;
    logic [31:0] trim_count;

    // Starts once after reset release; only a reset re-arms it, trim on reset bit unused
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            trim_state <= acr_pkg::ACR_TRIM_IDLE;
            trim_count <= 32'h0000_0000;
        end
        else
        begin
            case (trim_state)
                acr_pkg::ACR_TRIM_IDLE:
                begin
                    trim_count <= 32'h0000_0000;
                    trim_state <= acr_pkg::ACR_TRIM_RUN;
                end
                acr_pkg::ACR_TRIM_RUN:
                begin
                    trim_count <= trim_count + 32'h0000_0001;
                    if (trim_count >= 32'(TRIM_CYCLES - 1))
                        trim_state <= acr_pkg::ACR_TRIM_DONE;
                end
                acr_pkg::ACR_TRIM_DONE: trim_state <= acr_pkg::ACR_TRIM_DONE;
                default: trim_state <= acr_pkg::ACR_TRIM_IDLE;
            endcase
        end
    end
    assign trim_busy = (trim_state != acr_pkg::ACR_TRIM_DONE);

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_trim_busy <= 1'b1;
        else
            o_trim_busy <= trim_busy;
    end

    // ------------------------------------------------------------
    // DAC level control, one lane per channel
    // ------------------------------------------------------------
    acr_pkg::acr_ramp_t ramp_rate;
    logic [5:0] ramp_div;
    logic [5:0] frame_count;
    logic ramp_step;
    logic [7:0] applied [2];
    logic [7:0] target [2];
    logic [1:0] dac_silence;
    logic [1:0] zero_mute;
    logic [1:0] written;

    assign ramp_rate = acr_pkg::acr_ramp_t'(dac_control[1:0]);
    assign dac_silence = {dac_control[acr_pkg::DAC_R_SIL_BIT], dac_control[acr_pkg::DAC_L_SIL_BIT]};
    assign written = {i_wr && i_addr == acr_pkg::ADDR_RIGHT_VOLUME,
        i_wr && i_addr == acr_pkg::ADDR_LEFT_VOLUME};

    // Step divider in frame clock periods
    always_comb
    begin
        case (ramp_rate)
            acr_pkg::ACR_RAMP_4: ramp_div = acr_pkg::RAMP_DIV_4;
            acr_pkg::ACR_RAMP_16: ramp_div = acr_pkg::RAMP_DIV_16;
            acr_pkg::ACR_RAMP_32: ramp_div = acr_pkg::RAMP_DIV_32;
            default: ramp_div = acr_pkg::RAMP_DIV_8;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            frame_count <= 6'h00;
        else if (i_frame_tick)
            frame_count <= (frame_count + 6'h01 >= ramp_div) ? 6'h00 : frame_count + 6'h01;
    end
    assign ramp_step = i_frame_tick && (frame_count + 6'h01 >= ramp_div);

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_lane
            logic [9:0] run_count;
            logic [9:0] zc_count;

            // Zero-run detector on incoming samples
            always_ff @(posedge i_mclk or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    run_count <= 10'h000;
                    zero_mute[ch] <= 1'b0;
                end
                else if (i_sample_valid[ch])
                begin
                    if (!i_sample_static[ch])
                    begin
                        run_count <= 10'h000;
                        zero_mute[ch] <= 1'b0;
                    end
                    else if (run_count >= acr_pkg::ZERO_RUN_LEN - 10'h001)
                        zero_mute[ch] <= dac_control[acr_pkg::DAC_ZRUN_BIT];
                    else
                        run_count <= run_count + 10'h001;
                end
            end

            // Target level: attenuation code or full mute
            always_comb
            begin
                if (dac_silence[ch] || zero_mute[ch])
                    target[ch] = acr_pkg::VOL_MUTE_CODE;
                else if ((ch == 0 ? left_output_volume : right_output_volume) > acr_pkg::VOL_MAX_CODE)
                    target[ch] = acr_pkg::VOL_MUTE_CODE;
                else
                    target[ch] = (ch == 0) ? left_output_volume : right_output_volume;
            end

            // Applied level moves by ramp or zero crossing
            always_ff @(posedge i_mclk or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    applied[ch] <= acr_pkg::REG_RESET;
                    zc_count <= 10'h000;
                end
                else if (applied[ch] == target[ch])
                    zc_count <= 10'h000;
                else if (!dac_control[acr_pkg::DAC_STYLE_BIT])
                begin
                    if (ramp_step)
                        applied[ch] <= (applied[ch] < target[ch]) ? applied[ch] + 8'h01
                            : applied[ch] - 8'h01;
                end
                else if (i_sample_valid[ch])
                begin
                    zc_count <= zc_count + 10'h001;
                    if (i_zero_cross[ch] || zc_count >= acr_pkg::ZC_TIMEOUT - 10'h001)
                    begin
                        applied[ch] <= target[ch];
                        zc_count <= 10'h000;
                    end
                end
            end

            // Pending flag: a new write wins over completion
            always_ff @(posedge i_mclk or negedge i_nrst)
            begin
                if (!i_nrst)
                    level_pending[ch] <= 1'b0;
                else if (written[ch])
                    level_pending[ch] <= 1'b1;
                else if (applied[ch] == target[ch])
                    level_pending[ch] <= 1'b0;
            end

            always_ff @(posedge i_mclk or negedge i_nrst)
            begin
                if (!i_nrst)
                    o_dac_mute[ch] <= 1'b0;
                else
                    o_dac_mute[ch] <= (applied[ch] >= acr_pkg::VOL_MUTE_CODE);
            end
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_left_level <= acr_pkg::REG_RESET;
            o_right_level <= acr_pkg::REG_RESET;
        end
        else
        begin
            o_left_level <= applied[0];
            o_right_level <= applied[1];
        end
    end

    // ------------------------------------------------------------
    // Peak meters, sticky until status read
    // ------------------------------------------------------------
    assign status_read = i_rd && !spi_mode && i_addr == acr_pkg::ADDR_CONVERTER_STATUS;

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            left_peak_meter <= 3'h0;
            right_peak_meter <= 3'h0;
        end
        else
        begin
            // A new peak in the read cycle survives the clear
            if (status_read)
                left_peak_meter <= i_peak_code[2:0];
            else if (i_peak_code[2:0] > left_peak_meter)
                left_peak_meter <= i_peak_code[2:0];
            if (status_read)
                right_peak_meter <= i_peak_code[5:3];
            else if (i_peak_code[5:3] > right_peak_meter)
                right_peak_meter <= i_peak_code[5:3];
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb
    begin
        next_rdata = 8'h00;
        if (!spi_mode)
        begin
            case (i_addr)
                acr_pkg::ADDR_ADC_CONTROL: next_rdata = adc_control
                    | {6'h00, trim_busy, clock_error};
                acr_pkg::ADDR_DAC_CONTROL: next_rdata = dac_control;
                acr_pkg::ADDR_LEFT_VOLUME: next_rdata = left_output_volume;
                acr_pkg::ADDR_RIGHT_VOLUME: next_rdata = right_output_volume;
                acr_pkg::ADDR_SERIAL_PORT_FORMAT: next_rdata = serial_port_format;
                acr_pkg::ADDR_CONVERTER_STATUS: next_rdata = {level_pending[1], level_pending[0],
                    right_peak_meter, left_peak_meter};
                acr_pkg::ADDR_CLOCK_RATIO: next_rdata = clock_ratio_control;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_rdata <= 8'h00;
        else if (i_rd)
            o_rdata <= next_rdata;
    end

endmodule

`default_nettype wire

// *** sim/acr_host.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Host side of the register port
// ------------------------------------------------------------
module acr_host (
    input wire logic i_mclk,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output logic [7:0] o_addr = 8'h00,
    output logic [7:0] o_wdata = 8'h00,
    input wire logic [7:0] i_rdata
);
    // One-cycle write strobe; released fields show inverted values
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(negedge i_mclk);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask

    // One-cycle read strobe; data is settled one edge later
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_mclk);
        o_rd = 1'b1;
        o_addr = a;
        @(negedge i_mclk);
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rdata;
    endtask
endmodule

`default_nettype wire

// *** sim/acr_regs_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module acr_regs_checker #(
    parameter int TRIM_CYCLES = 20
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_spi_mode,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] o_rdata,
    input wire logic i_master_mode,
    input wire logic i_frame_tick,
    input wire logic [1:0] i_sample_valid,
    input wire acr_pkg::acr_cfg_t o_cfg,
    input wire logic [7:0] o_left_level,
    input wire logic [7:0] o_right_level,
    input wire logic [1:0] o_dac_mute,
    input wire logic o_trim_busy
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    int trim_cnt;

    // Cycles since reset release, saturating
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            trim_cnt <= 0;
        else if (trim_cnt < 100000)
            trim_cnt <= trim_cnt + 1;
    end

    chk_rdata_holds: assert property (!i_rd |=> $stable(o_rdata))
        else $error("read data changed idle");
    chk_spi_read_zero: assert property (i_rd && i_spi_mode && $past(i_spi_mode)
        && $past(i_spi_mode, 2) && $past(i_spi_mode, 3) |=> o_rdata == 8'h00)
        else $error("write-only read gave data");
    chk_unmapped_zero: assert property (i_rd && (i_addr == 8'h00 || i_addr > 8'h07)
        |=> o_rdata == 8'h00)
        else $error("unmapped read gave data");
    chk_left_mute: assert property (o_dac_mute[0] == (o_left_level >= 8'hE4))
        else $error("left mute vs level");
    chk_right_mute: assert property (o_dac_mute[1] == (o_right_level >= 8'hE4))
        else $error("right mute vs level");
    chk_level_cause: assert property ($changed(o_left_level) |-> $past(i_frame_tick)
        || $past(i_frame_tick, 2) || $past(i_sample_valid[0]) || $past(i_sample_valid[0], 2))
        else $error("left level moved uncaused");
    chk_ramp_step: assert property ($changed(o_left_level) && !$past(i_sample_valid[0])
        && !$past(i_sample_valid[0], 2)
        |-> 8'(o_left_level - $past(o_left_level)) inside {8'h01, 8'hFF})
        else $error("ramp step too big");
    chk_trim_min: assert property (trim_cnt < TRIM_CYCLES |-> o_trim_busy)
        else $error("trim busy dropped early");
    chk_trim_max: assert property (o_trim_busy |-> trim_cnt <= TRIM_CYCLES + 2)
        else $error("trim busy held too long");
    chk_slave_ratio: assert property (!i_master_mode && !$past(i_master_mode)
        && !$past(i_master_mode, 2) && !$past(i_master_mode, 3)
        |-> o_cfg.master_clock_ratio == 2'b00)
        else $error("ratio active in slave");

    cover property ($rose(o_dac_mute[0]));
    cover property ($fell(o_trim_busy));
    cover property (i_rd && i_spi_mode);
endmodule

bind acr_regs acr_regs_checker #(.TRIM_CYCLES(TRIM_CYCLES)) u_chk (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_spi_mode(i_spi_mode), .i_rd(i_rd),
    .i_addr(i_addr), .o_rdata(o_rdata), .i_master_mode(i_master_mode),
    .i_frame_tick(i_frame_tick), .i_sample_valid(i_sample_valid), .o_cfg(o_cfg),
    .o_left_level(o_left_level), .o_right_level(o_right_level),
    .o_dac_mute(o_dac_mute), .o_trim_busy(o_trim_busy)
);

`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Register bank bench
// ------------------------------------------------------------
module tb_top;
    logic i_mclk, i_nrst, i_spi_mode, wr, rd, master_mode, clock_error, frame_tick, trim_busy;
    logic [7:0] addr, wdata, rdata, left_level, right_level, d;
    logic [1:0] sample_valid, sample_static, zero_cross, dac_mute;
    logic [5:0] peak_code;
    acr_pkg::acr_cfg_t cfg;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [7:0] rw_exp [1:8] = '{8'hFC, 8'h7B, 8'hFF, 8'hFF, 8'h7F, 8'hC0, 8'h03, 8'h00};
    int ramp_n [4] = '{8, 4, 16, 32};

    acr_regs #(.TRIM_CYCLES(20)) uut (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_spi_mode(i_spi_mode), .i_wr(wr), .i_rd(rd),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_master_mode(master_mode),
        .i_clock_error(clock_error), .i_frame_tick(frame_tick),
        .i_sample_valid(sample_valid), .i_sample_static(sample_static),
        .i_zero_cross(zero_cross), .i_peak_code(peak_code), .o_cfg(cfg),
        .o_left_level(left_level), .o_right_level(right_level), .o_dac_mute(dac_mute),
        .o_trim_busy(trim_busy)
    );

    acr_host host (
        .i_mclk(i_mclk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata)
    );

    // 20 MHz clock
    initial
    begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    // Hang guard
    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            fails++;
            conclude();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, d);
        check(name, d, exp);
    endtask

    // Reset pulse, then wait out the offset trim
    task automatic do_reset();
        @(negedge i_mclk);
        i_nrst = 1'b0;
        wait_n(2);
        i_nrst = 1'b1;
        wait_n(25);
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(negedge i_mclk);
            frame_tick = 1'b1;
            @(negedge i_mclk);
            frame_tick = 1'b0;
        end
        wait_n(3);
    endtask

    task automatic samples(input int ch, input int n, input logic st, input logic zc);
        repeat (n)
        begin
            @(negedge i_mclk);
            sample_valid[ch] = 1'b1;
            sample_static[ch] = st;
            zero_cross[ch] = zc;
            @(negedge i_mclk);
            sample_valid[ch] = 1'b0;
        end
        wait_n(3);
    endtask

    // Main sequence
    initial
    begin
        i_nrst = 1'b0;
        i_spi_mode = 1'b0;
        master_mode = 1'b1;
        clock_error = 1'b0;
        frame_tick = 1'b0;
        sample_valid = 2'b00;
        sample_static = 2'b00;
        zero_cross = 2'b00;
        peak_code = 6'h00;
        wait_n(2);
        i_nrst = 1'b1;
        rd_chk("trim busy", 8'h01, 8'h02);
        wait_n(25);
        for (int a = 8; a >= 0; a--)
        begin
            rd_chk("reset value", 8'(a), 8'h00);
            host.write_reg(8'(a), 8'hFF);
        end
        for (int a = 1; a < 9; a++)
            rd_chk("readback", 8'(a), rw_exp[a]);
        check("ratio code 3", 8'(cfg.master_clock_ratio), 8'h00);
        host.write_reg(8'h07, 8'h01);
        wait_n(2);
        check("ratio master", 8'(cfg.master_clock_ratio), 8'h01);
        master_mode = 1'b0;
        wait_n(4);
        check("ratio slave", 8'(cfg.master_clock_ratio), 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            host.write_reg(8'h05, {1'b0, 2'(k), 1'(k), 2'(k), 2'(k)});
            wait_n(2);
            check("deemphasis", 8'(cfg.tone_correction_select), 8'(k));
            check("clock edge", 8'(cfg.bit_clock_edge_select), 8'(k & 1));
            check("out format", 8'(cfg.output_word_format), 8'(k));
            check("in format", 8'(cfg.input_word_format), 8'(k));
        end
        for (int i = 0; i < 5; i++)
        begin
            host.write_reg(8'h01, 8'(8'h80 >> i));
            wait_n(2);
            check("adc fields", 8'(cfg[13:9]), 8'(8'h10 >> i));
        end
        i_spi_mode = 1'b1;
        wait_n(3);
        rd_chk("spi read", 8'h01, 8'h00);
        host.write_reg(8'h05, 8'h15);
        i_spi_mode = 1'b0;
        wait_n(3);
        rd_chk("spi write", 8'h05, 8'h15);
        clock_error = 1'b1;
        wait_n(3);
        rd_chk("clock fault", 8'h01, 8'h09);
        clock_error = 1'b0;
        wait_n(3);
        rd_chk("clock ok", 8'h01, 8'h08);
        peak_code = 6'h2A;
        wait_n(3);
        peak_code = 6'h00;
        wait_n(2);
        rd_chk("peak sticky", 8'h06, 8'hEA);
        rd_chk("peak cleared", 8'h06, 8'hC0);
        // Zero-cross style, codes, silence and zero runs
        do_reset();
        host.write_reg(8'h02, 8'h08);
        host.write_reg(8'h04, 8'hE3);
        samples(1, 3, 1'b0, 1'b0);
        check("zc wait", right_level, 8'h00);
        samples(1, 1, 1'b0, 1'b1);
        check("zc apply", right_level, 8'hE3);
        check("no mute", 8'(dac_mute), 8'h00);
        rd_chk("pending clear", 8'h06, 8'h00);
        host.write_reg(8'h04, 8'hE4);
        samples(1, 1, 1'b0, 1'b1);
        check("code mute", 8'(dac_mute), 8'h02);
        host.write_reg(8'h04, 8'h00);
        host.write_reg(8'h03, 8'h05);
        samples(1, 1, 1'b0, 1'b1);
        samples(0, 511, 1'b0, 1'b0);
        check("zc timeout early", left_level, 8'h00);
        samples(0, 1, 1'b0, 1'b0);
        check("zc timeout", left_level, 8'h05);
        host.write_reg(8'h02, 8'h18);
        samples(0, 1, 1'b0, 1'b1);
        check("left silence", 8'(dac_mute), 8'h01);
        host.write_reg(8'h02, 8'h48);
        samples(0, 1, 1'b0, 1'b1);
        samples(0, 511, 1'b1, 1'b1);
        check("zero run early", 8'(dac_mute), 8'h00);
        samples(0, 2, 1'b1, 1'b1);
        check("zero run mute", 8'(dac_mute), 8'h01);
        samples(0, 2, 1'b0, 1'b1);
        check("zero run release", 8'(dac_mute), 8'h00);
        // Ramp pace for every rate code
        foreach (ramp_n[r])
        begin
            do_reset();
            host.write_reg(8'h02, 8'(r));
            host.write_reg(8'h03, 8'h02);
            ticks(ramp_n[r] - 1);
            check("ramp hold", left_level, 8'h00);
            ticks(1);
            check("ramp step", left_level, 8'h01);
            ticks(ramp_n[r]);
            check("ramp end", left_level, 8'h02);
            rd_chk("ramp pending", 8'h06, 8'h00);
        end
        conclude();
    end
endmodule

`default_nettype wire
